// ===== rtl/roi_pkg.sv
// Constants, field layouts and carrier types for the window crop and checker.
// Assumes one clock domain; all coordinates are in pixel units.
package roi_pkg;
   localparam int COORD_W    = 12;
   localparam int NUM_SLOTS  = 4;
   localparam int SLOT_IDX_W = 2;
   localparam int CAUSE_W    = 7;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int PIX_W      = 16;
   localparam int IRQ_W      = 3;
   localparam int SHIFT_W    = 2;

   // Cause vector bit positions.
   localparam int CB_SENSOR = 0;
   localparam int CB_OVX    = 1;
   localparam int CB_OVY    = 2;
   localparam int CB_BNDX   = 3;
   localparam int CB_BNDY   = 4;
   localparam int CB_MINX   = 5;
   localparam int CB_MINY   = 6;

   // Interrupt status bit positions.
   localparam int IRQ_INVALID = 0;
   localparam int IRQ_VALID   = 1;
   localparam int IRQ_FRAME   = 2;

   // Control register fields.
   localparam int CTRL_MULTI  = 0;
   localparam int CTRL_IDX_LO = 2;
   localparam int CTRL_HSH_LO = 4;
   localparam int CTRL_VSH_LO = 6;

   localparam logic [COORD_W-1:0] MIN_COLS      = 12'h008;
   localparam logic [COORD_W-1:0] MIN_ROWS      = 12'h002;
   localparam logic [COORD_W-1:0] ALIGN_MASK    = 12'h003;
   localparam logic [COORD_W-1:0] FULL_COLS_RST = 12'h800;
   localparam logic [COORD_W-1:0] FULL_ROWS_RST = 12'h600;

   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WIN_COL   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_WIN_ROW   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_WIN_W     = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_WIN_H     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_SLOT_ENA  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_SLOT_COL  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SLOT_ROW  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_SLOT_W    = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_SLOT_H    = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_FULL_COLS = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_FULL_ROWS = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_CAUSE_ALL = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_CAUSE_CUR = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h3C;

   typedef logic [COORD_W-1:0] coord_t;

   typedef struct packed {
      logic   ena;
      coord_t col;
      coord_t row;
      coord_t width;
      coord_t height;
   } window_s;

   typedef struct packed {
      logic             valid;
      logic             sof;
      logic             eol;
      logic             eof;
      logic [PIX_W-1:0] data;
   } pixel_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_s;

   // Gray coded along the priority order of reporting.
   typedef enum logic [2:0] {
      CAUSE_NONE   = 3'h0,
      CAUSE_SENSOR = 3'h1,
      CAUSE_OVX    = 3'h3,
      CAUSE_OVY    = 3'h2,
      CAUSE_BNDX   = 3'h6,
      CAUSE_BNDY   = 3'h7,
      CAUSE_MINX   = 3'h5,
      CAUSE_MINY   = 3'h4
   } cause_e;
endpackage : roi_pkg

// ===== rtl/roi_slot_check.sv
// Per-window bound, minimum, alignment checks and pixel hit test.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module roi_slot_check
   import roi_pkg::*;
(
   input  wire roi_pkg::window_s         win,
   input  wire roi_pkg::coord_t          maxCols,
   input  wire roi_pkg::coord_t          maxRows,
   input  wire roi_pkg::coord_t          pixCol,
   input  wire roi_pkg::coord_t          pixRow,
   output logic [roi_pkg::CAUSE_W-1:0]   flags,
   output logic                          hit
);
   logic [COORD_W:0] colEnd;
   logic [COORD_W:0] rowEnd;

   assign colEnd = {1'b0, win.col} + {1'b0, win.width};
   assign rowEnd = {1'b0, win.row} + {1'b0, win.height};

   always_comb begin
      flags = '0;
      flags[CB_SENSOR] = win.ena && ((win.col | win.width) & ALIGN_MASK) != '0;
      flags[CB_BNDX]   = win.ena && colEnd > {1'b0, maxCols};
      flags[CB_BNDY]   = win.ena && rowEnd > {1'b0, maxRows};
      flags[CB_MINX]   = win.ena && win.width < MIN_COLS;
      flags[CB_MINY]   = win.ena && win.height < MIN_ROWS;
   end

   assign hit = win.ena && pixCol >= win.col && {1'b0, pixCol} < colEnd
                && pixRow >= win.row && {1'b0, pixRow} < rowEnd;
endmodule : roi_slot_check
`default_nettype wire

// ===== rtl/roi_overlap_check.sv
// Pairwise overlap test across all window slots in each axis.
// Combinational; only slots with their enable set take part.
`timescale 1ns/1ps
`default_nettype none
module roi_overlap_check
   import roi_pkg::*;
(
   input  wire roi_pkg::window_s [roi_pkg::NUM_SLOTS-1:0] slots,
   output logic                                          ovX,
   output logic                                          ovY
);
   function automatic logic spanMeet(input coord_t a, input coord_t aLen,
                                     input coord_t b, input coord_t bLen);
      spanMeet = ({1'b0, a} < {1'b0, b} + {1'b0, bLen})
                 && ({1'b0, b} < {1'b0, a} + {1'b0, aLen});
   endfunction : spanMeet

   logic [NUM_SLOTS*NUM_SLOTS-1:0] pairX;
   logic [NUM_SLOTS*NUM_SLOTS-1:0] pairY;

   for (genvar i = 0; i < NUM_SLOTS; i++) begin : gRow
      for (genvar j = 0; j < NUM_SLOTS; j++) begin : gCol
         if (j > i) begin : gPair
            logic both;
            assign both = slots[i].ena && slots[j].ena;
            assign pairX[i*NUM_SLOTS+j] = both && spanMeet(slots[i].col,
               slots[i].width, slots[j].col, slots[j].width);
            assign pairY[i*NUM_SLOTS+j] = both && spanMeet(slots[i].row,
               slots[i].height, slots[j].row, slots[j].height);
         end else begin : gNone
            assign pairX[i*NUM_SLOTS+j] = 1'b0;
            assign pairY[i*NUM_SLOTS+j] = 1'b0;
         end
      end
   end

   assign ovX = |pairX;
   assign ovY = |pairY;
endmodule : roi_overlap_check
`default_nettype wire

// ===== rtl/roi_window_config_checker.sv
// Window crop for the sensor pixel stream, multi-window merge and checker.
// Assumes the pixel source and register master share the one clock.
`timescale 1ns/1ps
`default_nettype none
module roi_window_config_checker
   import roi_pkg::*;
(
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire roi_pkg::reg_req_s        regReq,
   output logic [roi_pkg::DATA_W-1:0]    regRdata,
   input  wire roi_pkg::pixel_s          pixIn,
   output roi_pkg::pixel_s               pixOut,
   output logic                          irq,
   output logic                          cfgValid
);
   typedef struct packed {
      logic                            multi;
      logic [SLOT_IDX_W-1:0]           idx;
      logic [SHIFT_W-1:0]              hShift;
      logic [SHIFT_W-1:0]              vShift;
      window_s                         single;
      window_s [NUM_SLOTS-1:0]         slots;
      coord_t                          fullCols;
      coord_t                          fullRows;
      logic [CAUSE_W-1:0]              cause;
      cause_e                          cur;
      logic                            bad;
      logic [IRQ_W-1:0]                irqStat;
      logic [IRQ_W-1:0]                irqMask;
      logic [DATA_W-1:0]               rdata;
      pixel_s                          pixOut;
      coord_t                          pixCol;
      coord_t                          pixRow;
   } state_s;

   state_s q;
   state_s d;

   function automatic cause_e firstCause(input logic [CAUSE_W-1:0] v);
      if (v[CB_SENSOR]) firstCause = CAUSE_SENSOR;
      else if (v[CB_OVX]) firstCause = CAUSE_OVX;
      else if (v[CB_OVY]) firstCause = CAUSE_OVY;
      else if (v[CB_BNDX]) firstCause = CAUSE_BNDX;
      else if (v[CB_BNDY]) firstCause = CAUSE_BNDY;
      else if (v[CB_MINX]) firstCause = CAUSE_MINX;
      else if (v[CB_MINY]) firstCause = CAUSE_MINY;
      else firstCause = CAUSE_NONE;
   endfunction : firstCause

   // Clamp a size so start plus size stays within the reduced limit, or to zero if start is at or past it.
   function automatic coord_t clampSpan(input coord_t start, input coord_t size,
                                        input coord_t lim);
      coord_t room;
      room = lim - start;
      if (start >= lim) clampSpan = '0;
      else if (size > room) clampSpan = room;
      else clampSpan = size;
   endfunction : clampSpan

   function automatic logic [DATA_W-1:0] widen(input coord_t v);
      widen = {{(DATA_W-COORD_W){1'b0}}, v};
   endfunction : widen

   coord_t                  maxCols;
   coord_t                  maxRows;
   coord_t                  curCol;
   coord_t                  curRow;
   window_s                 singleEff;
   logic [CAUSE_W-1:0]      slotFlags [NUM_SLOTS];
   logic [NUM_SLOTS-1:0]    slotHit;
   logic [CAUSE_W-1:0]      causeNow;
   logic                    singleHit;
   logic                    ovX;
   logic                    ovY;
   logic                    keep;

   assign maxCols = q.fullCols >> q.hShift;
   assign maxRows = q.fullRows >> q.vShift;
   assign curCol  = pixIn.sof ? '0 : q.pixCol;
   assign curRow  = pixIn.sof ? '0 : q.pixRow;

   always_comb begin
      singleEff        = q.single;
      singleEff.ena    = 1'b1;
      singleEff.width  = clampSpan(q.single.col, q.single.width, maxCols);
      singleEff.height = clampSpan(q.single.row, q.single.height, maxRows);
   end

   for (genvar s = 0; s < NUM_SLOTS; s++) begin : gSlot
      roi_slot_check uCheck (
         .win     (q.slots[s]),
         .maxCols (maxCols),
         .maxRows (maxRows),
         .pixCol  (curCol),
         .pixRow  (curRow),
         .flags   (slotFlags[s]),
         .hit     (slotHit[s])
      );
   end

   roi_slot_check uSingle (
      .win     (singleEff),
      .maxCols (maxCols),
      .maxRows (maxRows),
      .pixCol  (curCol),
      .pixRow  (curRow),
      .flags   (),
      .hit     (singleHit)
   );

   roi_overlap_check uOverlap (
      .slots (q.slots),
      .ovX   (ovX),
      .ovY   (ovY)
   );

   always_comb begin
      causeNow = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         causeNow = causeNow | slotFlags[s];
      end
      causeNow[CB_OVX] = ovX;
      causeNow[CB_OVY] = ovY;
   end

   // A broken multi-window setup passes nothing rather than a mangled image.
   assign keep = q.multi ? (!(|causeNow) && |slotHit) : singleHit;

   always_comb begin
      logic [IRQ_W-1:0] evt;
      logic [IRQ_W-1:0] clr;
      logic             badNow;
      evt    = '0;
      clr    = '0;
      badNow = q.multi && |causeNow;
      d      = q;
      d.rdata = '0;

      if (regReq.wr) begin
         unique case (regReq.addr)
            OFS_CTRL: begin
               d.multi  = regReq.wdata[CTRL_MULTI];
               d.idx    = regReq.wdata[CTRL_IDX_LO +: SLOT_IDX_W];
               d.hShift = regReq.wdata[CTRL_HSH_LO +: SHIFT_W];
               d.vShift = regReq.wdata[CTRL_VSH_LO +: SHIFT_W];
            end
            OFS_WIN_COL:   d.single.col    = regReq.wdata[COORD_W-1:0];
            OFS_WIN_ROW:   d.single.row    = regReq.wdata[COORD_W-1:0];
            OFS_WIN_W:     d.single.width  = regReq.wdata[COORD_W-1:0];
            OFS_WIN_H:     d.single.height = regReq.wdata[COORD_W-1:0];
            OFS_SLOT_ENA:  d.slots[q.idx].ena    = regReq.wdata[0];
            OFS_SLOT_COL:  d.slots[q.idx].col    = regReq.wdata[COORD_W-1:0];
            OFS_SLOT_ROW:  d.slots[q.idx].row    = regReq.wdata[COORD_W-1:0];
            OFS_SLOT_W:    d.slots[q.idx].width  = regReq.wdata[COORD_W-1:0];
            OFS_SLOT_H:    d.slots[q.idx].height = regReq.wdata[COORD_W-1:0];
            OFS_FULL_COLS: d.fullCols = regReq.wdata[COORD_W-1:0];
            OFS_FULL_ROWS: d.fullRows = regReq.wdata[COORD_W-1:0];
            OFS_IRQ_STAT:  clr = regReq.wdata[IRQ_W-1:0];
            OFS_IRQ_MASK:  d.irqMask = regReq.wdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      if (regReq.rd) begin
         unique case (regReq.addr)
            OFS_CTRL: begin
               d.rdata[CTRL_MULTI]                 = q.multi;
               d.rdata[CTRL_IDX_LO +: SLOT_IDX_W]  = q.idx;
               d.rdata[CTRL_HSH_LO +: SHIFT_W]     = q.hShift;
               d.rdata[CTRL_VSH_LO +: SHIFT_W]     = q.vShift;
            end
            OFS_WIN_COL:   d.rdata = widen(q.single.col);
            OFS_WIN_ROW:   d.rdata = widen(q.single.row);
            OFS_WIN_W:     d.rdata = widen(q.single.width);
            OFS_WIN_H:     d.rdata = widen(q.single.height);
            OFS_SLOT_ENA: begin
               for (int s = 0; s < NUM_SLOTS; s++) begin
                  d.rdata[s] = q.slots[s].ena;
               end
            end
            OFS_SLOT_COL:  d.rdata = widen(q.slots[q.idx].col);
            OFS_SLOT_ROW:  d.rdata = widen(q.slots[q.idx].row);
            OFS_SLOT_W:    d.rdata = widen(q.slots[q.idx].width);
            OFS_SLOT_H:    d.rdata = widen(q.slots[q.idx].height);
            OFS_FULL_COLS: d.rdata = widen(q.fullCols);
            OFS_FULL_ROWS: d.rdata = widen(q.fullRows);
            OFS_CAUSE_ALL: d.rdata[CAUSE_W-1:0] = q.cause;
            OFS_CAUSE_CUR: d.rdata[2:0] = q.cur;
            OFS_IRQ_STAT:  d.rdata[IRQ_W-1:0] = q.irqStat;
            OFS_IRQ_MASK:  d.rdata[IRQ_W-1:0] = q.irqMask;
            default: ;
         endcase
      end

      // Checks run every cycle, so any slot, frame size or shift change is seen next edge.
      d.cause = causeNow;
      d.cur   = firstCause(causeNow);
      d.bad   = badNow;

      d.pixOut       = '0;
      d.pixOut.valid = pixIn.valid && keep;
      d.pixOut.data  = pixIn.data;
      if (pixIn.valid) begin
         d.pixOut.sof = pixIn.sof;
         d.pixOut.eol = pixIn.eol;
         d.pixOut.eof = pixIn.eof;
         if (pixIn.eol) begin
            d.pixCol = '0;
            d.pixRow = curRow + 12'h001;
         end else begin
            d.pixCol = curCol + 12'h001;
            d.pixRow = curRow;
         end
      end

      evt[IRQ_INVALID] = badNow && !q.bad;
      evt[IRQ_VALID]   = !badNow && q.bad;
      evt[IRQ_FRAME]   = pixIn.valid && pixIn.eof;
      // Set wins over a write-one clear landing in the same cycle.
      d.irqStat = (q.irqStat & ~clr) | evt;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q          <= '0;
         q.fullCols <= FULL_COLS_RST;
         q.fullRows <= FULL_ROWS_RST;
         q.cur      <= CAUSE_NONE;
      end else begin
         q <= d;
      end
   end

   assign regRdata = q.rdata;
   assign pixOut   = q.pixOut;
   assign irq      = |(q.irqStat & q.irqMask);
   assign cfgValid = (q.cause == '0);

   sequence slotColWrite;
      regReq.wr && regReq.addr == OFS_SLOT_COL;
   endsequence

   sequence causeRead;
      regReq.rd && regReq.addr == OFS_CAUSE_ALL;
   endsequence

   drop_outside_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      !q.multi && pixIn.valid && !singleHit |=> !pixOut.valid)
      else $error("pixel outside window was passed");

   keep_source_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      pixOut.valid |-> $past(pixIn.valid))
      else $error("output pixel without input pixel");

   width_limit_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      {1'b0, singleEff.col} + {1'b0, singleEff.width} <= {1'b0, maxCols}
      || singleEff.col >= maxCols)
      else $error("single window width passes reduced limit");

   merge_union_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      q.multi && !(|causeNow) && pixIn.valid && |slotHit |=> pixOut.valid)
      else $error("pixel in enabled window not merged");

   slot_select_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      slotColWrite |=> q.slots[$past(q.idx)].col == $past(regReq.wdata[COORD_W-1:0]))
      else $error("slot write missed the selected slot");

   cur_cause_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (q.cause == '0) == (q.cur == CAUSE_NONE))
      else $error("current cause disagrees with vector");

   cause_read_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      causeRead ##1 !regReq.wr |-> regRdata[CAUSE_W-1:0] == $past(q.cause)
      && regRdata[DATA_W-1:CAUSE_W] == '0)
      else $error("cause vector read back wrong");

   overlap_x_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      ovX |=> q.cause[CB_OVX])
      else $error("horizontal overlap not flagged");

   bound_y_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      q.slots[0].ena && {1'b0, q.slots[0].row} + {1'b0, q.slots[0].height}
      > {1'b0, maxRows} ##1 $stable(q.slots[0]) && $stable(maxRows)
      |-> q.cause[CB_BNDY])
      else $error("vertical bound not flagged");

   min_x_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      q.slots[1].ena && q.slots[1].width < MIN_COLS |=> q.cause[CB_MINX])
      else $error("narrow window not flagged");

   overlap_y_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      ovY |=> q.cause[CB_OVY])
      else $error("vertical overlap not flagged");

   sensor_bit_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      q.slots[0].ena && (q.slots[0].col & ALIGN_MASK) != '0 |=> q.cause[CB_SENSOR])
      else $error("sensor restriction not flagged");

   min_y_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      q.slots[0].ena && q.slots[0].height < MIN_ROWS |=> q.cause[CB_MINY])
      else $error("short window not flagged");

   idle_slot_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      q.slots == '0 |=> q.cause == '0)
      else $error("disabled slots raised a cause");

   sticky_set_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      pixIn.valid && pixIn.eof |=> q.irqStat[IRQ_FRAME])
      else $error("frame event lost");
endmodule : roi_window_config_checker
`default_nettype wire

// ===== test/pixel_source.sv
// Behavioural image sensor readout: one frame of pixels for each start pulse.
// Assumes the crop block never stalls; idle beats may sit between pixels.
`timescale 1ns/1ps
`default_nettype none
module pixel_source
   import roi_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       start,
   input  wire logic       gap,
   input  wire logic [7:0] cols,
   input  wire logic [7:0] rows,
   output roi_pkg::pixel_s pix,
   output logic            busy
);
   initial begin
      pix  = '0;
      busy = 1'b0;
      forever begin
         @(posedge clock);
         // Idle data is inverted every cycle so a stale pixel never looks fresh.
         if (!start) begin
            pix <= '{1'b0, 1'b0, 1'b0, 1'b0, ~pix.data};
         end else begin
            busy <= 1'b1;
            for (int r = 0; r < rows; r++) begin
               for (int c = 0; c < cols; c++) begin
                  pix <= '{1'b1, r == 0 && c == 0, c == cols - 1,
                           r == rows - 1 && c == cols - 1, {8'(r), 8'(c)}};
                  @(posedge clock);
                  if (gap) begin
                     pix <= '{1'b0, 1'b0, 1'b0, 1'b0, ~pix.data};
                     @(posedge clock);
                  end
               end
            end
            pix  <= '{1'b0, 1'b0, 1'b0, 1'b0, ~pix.data};
            busy <= 1'b0;
         end
      end
   end
endmodule : pixel_source
`default_nettype wire

// ===== test/test_roi_window_config_checker.sv
// Self-checking bench for the window crop, multi-window merge and checker.
// Assumes one 40 MHz clock; a reference model of the registers lives here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nErrors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_roi_window_config_checker;
   import roi_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, start = 1'b0, gap = 1'b0, multi;
   reg_req_s reqQ = '0;
   pixel_s pixIn, pixOut;
   logic [31:0] regRdata, d;
   logic irq, cfgValid, busy, se[4];
   logic [11:0] sc[4], sr[4], sw[4], sh[4], fullC, fullR, winCol, winRow, winW, winH;
   logic [1:0] hsh, vsh;
   logic [11:0] hc[9][9] = '{'{0,0,8,2,0,0,8,2,0}, '{2,0,8,2,0,0,0,0,0},
      '{0,0,8,2,4,8,8,2,1}, '{0,0,8,2,16,1,8,2,1}, '{60,0,8,2,0,0,0,0,0},
      '{0,15,8,2,0,0,0,0,0}, '{0,0,4,2,0,0,0,0,0}, '{0,0,8,1,0,0,0,0,0},
      '{0,0,8,2,0,0,8,2,0}};
   cause_e tbl[7] = '{CAUSE_SENSOR, CAUSE_OVX, CAUSE_OVY, CAUSE_BNDX, CAUSE_BNDY,
      CAUSE_MINX, CAUSE_MINY};
   int nErrors = 0, checked = 0, cycles = 0, keptSeen, seed = 32'h58d9;
   always #12.5 clock = ~clock;
   roi_window_config_checker uut (.clock(clock), .rst_n(rst_n), .regReq(reqQ),
      .regRdata(regRdata), .pixIn(pixIn), .pixOut(pixOut), .irq(irq), .cfgValid(cfgValid));
   pixel_source src (.clock(clock), .start(start), .gap(gap), .cols(8'h20), .rows(8'h08),
      .pix(pixIn), .busy(busy));
   function automatic logic [6:0] expCause();
      logic [6:0] v = '0;
      for (int i = 0; i < 4; i++) if (se[i]) begin
         if (((sc[i] | sw[i]) & ALIGN_MASK) != 0) v[CB_SENSOR] = 1'b1;
         if ({1'b0, sc[i]} + sw[i] > (fullC >> hsh)) v[CB_BNDX] = 1'b1;
         if ({1'b0, sr[i]} + sh[i] > (fullR >> vsh)) v[CB_BNDY] = 1'b1;
         if (sw[i] < MIN_COLS) v[CB_MINX] = 1'b1;
         if (sh[i] < MIN_ROWS) v[CB_MINY] = 1'b1;
         for (int j = i + 1; j < 4; j++) if (se[j]) begin
            if (sc[i] < sc[j] + sw[j] && sc[j] < sc[i] + sw[i]) v[CB_OVX] = 1'b1;
            if (sr[i] < sr[j] + sh[j] && sr[j] < sr[i] + sh[i]) v[CB_OVY] = 1'b1;
         end
      end
      return v;
   endfunction : expCause
   function automatic logic [2:0] curCode(logic [6:0] v);
      for (int b = 0; b < 7; b++) if (v[b]) return tbl[b];
      return CAUSE_NONE;
   endfunction : curCode
   function automatic bit keep(int c, int r);
      if (!multi) return c >= winCol && c < winCol + winW && r >= winRow && r < winRow + winH;
      if (expCause() != 0) return 1'b0;
      for (int i = 0; i < 4; i++)
         if (se[i] && c >= sc[i] && c < sc[i] + sw[i] && r >= sr[i] && r < sr[i] + sh[i])
            return 1'b1;
      return 1'b0;
   endfunction : keep
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reqQ <= '{a, v, 1'b1, 1'b0};
      @(posedge clock);
      reqQ.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reqQ <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock);
      reqQ.rd <= 1'b0;
      #1 v = regRdata;
   endtask : rd
   task automatic setCtrl(int idx);
      wr(OFS_CTRL, 32'({vsh, hsh, 2'(idx), 1'b0, multi}));
   endtask : setCtrl
   task automatic runFrame();
      int n = 0, exp = 0;
      keptSeen = 0;
      @(posedge clock);
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      #1;
      while (busy === 1'b1 && n < 2000) begin @(posedge clock); #1 n++; end
      `CHK("frameDone", 1'b0, busy)
      repeat (3) @(posedge clock);
      for (int r = 0; r < 8; r++) for (int c = 0; c < 32; c++) exp += keep(c, r);
      `CHK("keptCount", exp, keptSeen)
   endtask : runFrame
   task automatic applyAndCheck();
      wr(OFS_FULL_COLS, 32'(fullC));
      wr(OFS_FULL_ROWS, 32'(fullR));
      for (int i = 3; i >= 0; i--) begin
         setCtrl(i);
         wr(OFS_SLOT_COL, 32'(sc[i]));
         wr(OFS_SLOT_ROW, 32'(sr[i]));
         wr(OFS_SLOT_W, 32'(sw[i]));
         wr(OFS_SLOT_H, 32'(sh[i]));
         wr(OFS_SLOT_ENA, 32'(se[i]));
      end
      wr(OFS_WIN_COL, 32'(winCol));
      wr(OFS_WIN_ROW, 32'(winRow));
      wr(OFS_WIN_W, 32'(winW));
      wr(OFS_WIN_H, 32'(winH));
      rd(OFS_CAUSE_ALL, d);
      `CHK("causeAll", 32'(expCause()), d)
      rd(OFS_CAUSE_CUR, d);
      `CHK("causeCur", 32'(curCode(expCause())), d)
      `CHK("cfgValid", expCause() == 0, cfgValid)
      rd(OFS_SLOT_ENA, d);
      `CHK("slotEna", 32'({se[3], se[2], se[1], se[0]}), d)
      rd(OFS_SLOT_COL, d);
      `CHK("slotCol", 32'(sc[0]), d)
      rd(OFS_CTRL, d);
      `CHK("ctrl", 32'({vsh, hsh, 2'b00, 1'b0, multi}), d)
      gap <= 1'($random(seed));
      runFrame();
   endtask : applyAndCheck
   always @(posedge clock) if (rst_n && pixOut.valid === 1'b1) begin
      keptSeen++;
      `CHK("keptPixel", 1'b1, keep(pixOut.data[7:0], pixOut.data[15:8]))
   end
   always @(posedge clock) if (++cycles == 40000) begin nErrors++; wrap_up(); end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      rd(OFS_FULL_COLS, d);
      `CHK("fullColsRst", 32'(FULL_COLS_RST), d)
      rd(OFS_CAUSE_ALL, d);
      `CHK("causeRst", 32'h0, d)
      `CHK("validRst", 1'b1, cfgValid)
      rd(8'h40, d);
      `CHK("unmapped", 32'h0, d)
      $display("test reset done");
      multi = 1'b1; hsh = 0; vsh = 0; fullC = 64; fullR = 16;
      {winCol, winRow, winW, winH} = {12'h2, 12'h1, 12'h8, 12'h2};
      for (int k = 0; k < 9; k++) begin
         {sc[0], sr[0], sw[0], sh[0]} = {hc[k][0], hc[k][1], hc[k][2], hc[k][3]};
         {sc[1], sr[1], sw[1], sh[1]} = {hc[k][4], hc[k][5], hc[k][6], hc[k][7]};
         {se[0], se[1], se[2], se[3]} = {1'b1, hc[k][8][0], 2'b00};
         {sc[2], sr[2], sw[2], sh[2], sc[3], sr[3], sw[3], sh[3]} = '0;
         applyAndCheck();
      end
      $display("test corner causes done");
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_IRQ_STAT, 32'h7);
      sc[0] = 12'h2;
      setCtrl(0);
      wr(OFS_SLOT_COL, 32'h2);
      wr(OFS_SLOT_COL, 32'h0);
      rd(OFS_IRQ_STAT, d);
      `CHK("irqStat", 32'h3, d)
      `CHK("irqMasked", 1'b0, irq)
      wr(OFS_IRQ_MASK, 32'h2);
      #1 `CHK("irqRaised", 1'b1, irq)
      wr(OFS_IRQ_STAT, 32'h3);
      #1 `CHK("irqCleared", 1'b0, irq)
      $display("test interrupt done");
      for (int k = 0; k < 24; k++) begin
         multi = 1'($random(seed));
         hsh = multi ? 2'($random(seed) & 1) : 2'h0;
         vsh = multi ? 2'($random(seed) & 1) : 2'h0;
         fullC = 12'(16 + ($random(seed) & 31));
         fullR = 12'(4 + ($random(seed) & 7));
         for (int i = 0; i < 4; i++) begin
            se[i] = 1'($random(seed));
            sc[i] = 12'(($random(seed) & 7) * 4 + (k % 5 == 0));
            sr[i] = 12'($random(seed) & 7);
            sw[i] = 12'((($random(seed) & 3) + 1) * 4);
            sh[i] = 12'(($random(seed) & 3) + 1);
         end
         winCol = 12'($random(seed) & 7);
         winW = 12'(($random(seed) & 7) + 1);
         winRow = 12'($random(seed) & 1);
         winH = 12'(($random(seed) & 1) + 1);
         applyAndCheck();
      end
      $display("test random configs done");
      wrap_up();
   end
endmodule : test_roi_window_config_checker
`default_nettype wire
